// ==== design/tmr_pkg.sv ====
package tmr_pkg;

	// Register byte addresses on the AXI4-Lite slave
	localparam logic [4:0] CTRL0_OFFSET     = 5'h00;
	localparam logic [4:0] CTRL1_OFFSET     = 5'h04;
	localparam logic [4:0] CNT_LOW_OFFSET   = 5'h08;
	localparam logic [4:0] CNT_HIGH_OFFSET  = 5'h0c;
	localparam logic [4:0] CMPA_LOW_OFFSET  = 5'h10;
	localparam logic [4:0] CMPA_HIGH_OFFSET = 5'h14;
	localparam logic [4:0] IRQ_STAT_OFFSET  = 5'h18;
	localparam logic [4:0] IRQ_MASK_OFFSET  = 5'h1c;

	// Control 0 field positions
	localparam int PAUSE_POS  = 7;
	localparam int CKSEL_POS  = 4;
	localparam int ENABLE_POS = 3;
	localparam int CMPP_POS   = 0;

	// Control 1 field positions
	localparam int MODE_POS   = 6;
	localparam int OUTFN_POS  = 4;
	localparam int INIT_POS   = 3;
	localparam int INV_POS    = 2;
	localparam int SWAP_POS   = 1;
	localparam int CLRSEL_POS = 0;

	// Status and mask bit positions
	localparam int FLAG_A_POS = 0;
	localparam int FLAG_P_POS = 1;

	// Widths and reset values
	localparam int CNT_WIDTH = 10;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [9:0] CNT_RESET  = 10'h000;
	localparam logic [9:0] CNT_MAX    = 10'h3ff;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Operating modes
	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_PWM     = 2'b10,
		MODE_TIMER   = 2'b11
	} mode_type;

	// Output function selector in compare mode
	localparam logic [1:0] OUT_NOCHANGE = 2'b00;
	localparam logic [1:0] OUT_LOW      = 2'b01;
	localparam logic [1:0] OUT_HIGH     = 2'b10;
	localparam logic [1:0] OUT_TOGGLE   = 2'b11;

endpackage

// ==== design/tmr_counter_core.sv ====
`timescale 1ns/100ps
`default_nettype none

module tmr_counter_core
	import tmr_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Control
	input  wire logic       tick_i,
	input  wire logic       enable_i,
	input  wire logic       enable_rise_i,
	input  wire logic       pause_i,
	input  wire logic       clear_i,
	// State
	output logic [9:0]      count_o
);

	// Counter: restart, clear on selected match, else count
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			count_o <= CNT_RESET;
		end else if (enable_rise_i) begin
			count_o <= CNT_RESET;
		end else if (enable_i && !pause_i && tick_i) begin
			if (clear_i)
				count_o <= CNT_RESET;
			else
				count_o <= count_o + 10'h001;
		end
	end

endmodule // tmr_counter_core

`default_nettype wire

// ==== design/tmr_regs_top.sv ====
// Summary of operation
// - Compare mode pin starts at initial bit
// - PWM mode initial bit picks active level
// - Timer mode ignores initial and invert bits
// - Invert bit flips output pin level in compare and PWM modes
// - Swap bit exchanges period and duty comparators
// - Clear select one clears on match A
// - Clear select zero clears on P/overflow
// - Overflow clear only when compare-P zero
// - PWM and capture ignore clear select
// - Read-only counter low byte, resets zero
// - Counter high byte, bits 7-2 zero
// - Read/write compare-A low byte, resets zero
// - Compare-A high byte holds bits 9-8
// - Compare-P matches counter bits 9-7
// - Enable rising edge restarts counter, pin
// - Compare mode pin changes on A only
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none

module tmr_regs_top
	import tmr_pkg::*;
(
	// Clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        NRST_I,
	// Selected timer clock event
	input  wire logic        TICK_I,
	// AXI4-Lite write address and data
	input  wire logic [4:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	// AXI4-Lite read
	input  wire logic [4:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	// Timer output and interrupt
	output logic             TIMER_OUTPUT_PIN_O,
	output logic             IRQ_O
);

	// Software registers
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [9:0] compare_a_value_reg;
	logic [1:0] irq_stat_reg;
	logic [1:0] irq_mask_reg;
	logic       enable_d_reg;
	logic       pin_level_reg;
	// Bus state
	logic [4:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic       aw_held_reg;
	logic       w_held_reg;
	logic [9:0] count;

	// Field decode
	logic       timer_enable_bit;
	logic       pause_bit;
	logic [2:0] compare_p_value;
	mode_type   mode;
	logic [1:0] out_fn;
	logic       output_initial_level_bit;
	logic       output_invert_bit;
	logic       period_duty_swap_bit;
	logic       clear_source_select;

	assign timer_enable_bit = ctrl0_reg[ENABLE_POS];
	assign pause_bit        = ctrl0_reg[PAUSE_POS];
	assign compare_p_value  = ctrl0_reg[CMPP_POS +: 3];
	assign mode             = mode_type'(ctrl1_reg[MODE_POS +: 2]);
	assign out_fn           = ctrl1_reg[OUTFN_POS +: 2];
	assign output_initial_level_bit = ctrl1_reg[INIT_POS];
	assign output_invert_bit        = ctrl1_reg[INV_POS];
	assign period_duty_swap_bit     = ctrl1_reg[SWAP_POS];
	assign clear_source_select      = ctrl1_reg[CLRSEL_POS];

	// Comparators
	logic match_a;
	logic match_p;
	logic overflow;
	logic enable_rise;
	logic counting;
	logic clear_cnt;
	assign match_p  = (compare_p_value != 3'h0) &&
	                  (count[9:7] == compare_p_value) && (count[6:0] == 7'h00);
	assign match_a  = (count == compare_a_value_reg);
	assign overflow = (count == CNT_MAX);
	assign enable_rise = timer_enable_bit && !enable_d_reg;
	assign counting = timer_enable_bit && !pause_bit && TICK_I;

	// Clear source selection; period comparator is the one that clears
	always_comb begin
		clear_cnt = 1'b0;
		unique case (mode)
			MODE_PWM: begin
				if (period_duty_swap_bit)
					clear_cnt = match_a;
				else
					clear_cnt = (compare_p_value == 3'h0) ? overflow : match_p;
			end
			MODE_CAPTURE: clear_cnt = 1'b0;
			MODE_COMPARE, MODE_TIMER: begin
				if (clear_source_select)
					clear_cnt = match_a;
				else
					clear_cnt = (compare_p_value == 3'h0) ? overflow : match_p;
			end
		endcase
	end

	tmr_counter_core u_core (
		.clk_i         (SYS_CLK_I),
		.nrst_i        (NRST_I),
		.tick_i        (TICK_I),
		.enable_i      (timer_enable_bit),
		.enable_rise_i (enable_rise),
		.pause_i       (pause_bit),
		.clear_i       (clear_cnt),
		.count_o       (count)
	);

	// Enable edge history
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I)
			enable_d_reg <= 1'b0;
		else
			enable_d_reg <= timer_enable_bit;
	end

	// PWM active phase: duty against the non-period comparator
	logic       pwm_active;
	logic [9:0] duty_value;
	always_comb begin
		if (period_duty_swap_bit)
			duty_value = {compare_p_value, 7'h00};
		else
			duty_value = compare_a_value_reg;
		// Duty of zero for P means full 1024 count
		if (period_duty_swap_bit && compare_p_value == 3'h0)
			pwm_active = 1'b1;
		else
			pwm_active = (count < duty_value);
	end

	// Compare mode pin state, held until next A match or restart
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			pin_level_reg <= 1'b0;
		end else if (enable_rise) begin
			pin_level_reg <= output_initial_level_bit;
		end else if (mode == MODE_COMPARE && counting && match_a) begin
			unique case (out_fn)
				OUT_NOCHANGE: pin_level_reg <= pin_level_reg;
				OUT_LOW:      pin_level_reg <= 1'b0;
				OUT_HIGH:     pin_level_reg <= 1'b1;
				OUT_TOGGLE:   pin_level_reg <= !pin_level_reg;
			endcase
		end
	end

	// Pin driver; timer mode parks pin low since it is unused
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			TIMER_OUTPUT_PIN_O <= 1'b0;
		end else begin
			unique case (mode)
				MODE_TIMER, MODE_CAPTURE: TIMER_OUTPUT_PIN_O <= 1'b0;
				MODE_COMPARE:
					TIMER_OUTPUT_PIN_O <= pin_level_reg ^ output_invert_bit;
				MODE_PWM: begin
					unique case (out_fn)
						OUT_LOW: TIMER_OUTPUT_PIN_O <=
							output_initial_level_bit ^ output_invert_bit;
						OUT_NOCHANGE: TIMER_OUTPUT_PIN_O <=
							!output_initial_level_bit ^ output_invert_bit;
						default: TIMER_OUTPUT_PIN_O <= (pwm_active ?
							output_initial_level_bit :
							!output_initial_level_bit) ^ output_invert_bit;
					endcase
				end
			endcase
		end
	end

	// Write channel capture: address and data in either order
	logic do_write;
	assign do_write = aw_held_reg && w_held_reg && !BVALID_O;
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 5'h00;
			wdata_reg   <= 32'h0000_0000;
			BVALID_O    <= 1'b0;
			BRESP_O     <= RESP_OKAY;
			AWREADY_O   <= 1'b1;
			WREADY_O    <= 1'b1;
		end else begin
			if (AWVALID_I && AWREADY_O) begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= AWADDR_I;
				AWREADY_O   <= 1'b0;
			end
			if (WVALID_I && WREADY_O) begin
				w_held_reg <= 1'b1;
				wdata_reg  <= WSTRB_I[0] ? WDATA_I : 32'h0000_0000;
				WREADY_O   <= 1'b0;
			end
			if (do_write) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				BVALID_O    <= 1'b1;
				BRESP_O     <= (awaddr_reg > IRQ_MASK_OFFSET ||
				                awaddr_reg[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
			end else if (BVALID_O && BREADY_I) begin
				// Both channels reopen only once the answer is taken
				BVALID_O  <= 1'b0;
				AWREADY_O <= 1'b1;
				WREADY_O  <= 1'b1;
			end
		end
	end

	// Register writes; a write without lane 0 is dropped
	logic wr_en;
	logic wstrb0_reg;
	assign wr_en = do_write && wstrb0_reg;
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I)
			wstrb0_reg <= 1'b0;
		else if (WVALID_I && WREADY_O)
			wstrb0_reg <= WSTRB_I[0];
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			ctrl0_reg <= BYTE_RESET;
			ctrl1_reg <= BYTE_RESET;
			compare_a_value_reg <= CNT_RESET;
			irq_mask_reg <= 2'h0;
		end else if (wr_en) begin
			unique case (awaddr_reg)
				CTRL0_OFFSET: ctrl0_reg <= wdata_reg[7:0];
				CTRL1_OFFSET: ctrl1_reg <= wdata_reg[7:0];
				CMPA_LOW_OFFSET: compare_a_value_reg[7:0] <= wdata_reg[7:0];
				CMPA_HIGH_OFFSET: compare_a_value_reg[9:8] <= wdata_reg[1:0];
				IRQ_MASK_OFFSET: irq_mask_reg <= wdata_reg[1:0];
				default: ;
			endcase
		end
	end

	// Sticky flags; a new event wins over a write-one clear
	logic set_a;
	logic set_p;
	assign set_a = counting && match_a;
	assign set_p = counting && match_p && !(clear_source_select &&
	               (mode == MODE_COMPARE || mode == MODE_TIMER));
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			irq_stat_reg <= 2'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_en &&
			    awaddr_reg == IRQ_STAT_OFFSET) ? wdata_reg[1:0] : 2'h0))
			    | {set_p, set_a};
		end
	end

	// Interrupt level output
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(irq_stat_reg & irq_mask_reg);
	end

	// Read channel: one cycle after address, held until taken
	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			RVALID_O  <= 1'b0;
			RDATA_O   <= 32'h0000_0000;
			RRESP_O   <= RESP_OKAY;
			ARREADY_O <= 1'b1;
		end else if (ARVALID_I && ARREADY_O) begin
			RVALID_O  <= 1'b1;
			ARREADY_O <= 1'b0;
			RRESP_O  <= RESP_OKAY;
			unique case (ARADDR_I)
				CTRL0_OFFSET: RDATA_O <= {24'h0, ctrl0_reg};
				CTRL1_OFFSET: RDATA_O <= {24'h0, ctrl1_reg};
				CNT_LOW_OFFSET: RDATA_O <= {24'h0, count[7:0]};
				CNT_HIGH_OFFSET: RDATA_O <= {30'h0, count[9:8]};
				CMPA_LOW_OFFSET: RDATA_O <= {24'h0, compare_a_value_reg[7:0]};
				CMPA_HIGH_OFFSET: RDATA_O <= {30'h0, compare_a_value_reg[9:8]};
				IRQ_STAT_OFFSET: RDATA_O <= {30'h0, irq_stat_reg};
				IRQ_MASK_OFFSET: RDATA_O <= {30'h0, irq_mask_reg};
				default: begin
					RDATA_O <= 32'h0000_0000;
					RRESP_O <= RESP_SLVERR;
				end
			endcase
		end else if (RVALID_O && RREADY_I) begin
			RVALID_O  <= 1'b0;
			ARREADY_O <= 1'b1;
		end
	end

endmodule // tmr_regs_top

`default_nettype wire

// ==== dv/tmr_regs_props.sv ====
`timescale 1ns/100ps
`default_nettype none

module tmr_regs_props
	import tmr_pkg::*;
(
	// Clock and reset
	input wire logic        SYS_CLK_I,
	input wire logic        NRST_I,
	// Write handshakes
	input wire logic        AWVALID_I,
	input wire logic        AWREADY_O,
	input wire logic        WVALID_I,
	input wire logic        WREADY_O,
	input wire logic [1:0]  BRESP_O,
	input wire logic        BVALID_O,
	input wire logic        BREADY_I,
	// Read handshakes
	input wire logic [4:0]  ARADDR_I,
	input wire logic        ARVALID_I,
	input wire logic        ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic [1:0]  RRESP_O,
	input wire logic        RVALID_O,
	input wire logic        RREADY_I,
	// Pin and interrupt
	input wire logic        TIMER_OUTPUT_PIN_O,
	input wire logic        IRQ_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);

	// Remember whether the read in flight targets the counter high byte
	logic high_reg;
	always_ff @(posedge SYS_CLK_I) begin
		if (ARVALID_I && ARREADY_O)
			high_reg <= (ARADDR_I == CNT_HIGH_OFFSET);
	end

	property p_rd_hold;
		RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read answer dropped");
	property p_wr_hold;
		BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write answer dropped");
	property p_rd_ans;
		ARVALID_I && ARREADY_O |=> RVALID_O;
	endproperty
	a_rd_ans: assert property (p_rd_ans)
		else $error("read answer late");
	property p_wr_ans;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O;
	endproperty
	a_wr_ans: assert property (p_wr_ans)
		else $error("write answer late");
	property p_one_rd;
		RVALID_O |-> !ARREADY_O;
	endproperty
	a_one_rd: assert property (p_one_rd)
		else $error("second read taken");
	property p_bad_rd;
		ARVALID_I && ARREADY_O && ARADDR_I[1:0] != 2'h0
			|=> RRESP_O == RESP_SLVERR && RDATA_O == 32'h0;
	endproperty
	a_bad_rd: assert property (p_bad_rd)
		else $error("unaligned read not refused");
	property p_hi_zero;
		RVALID_O && high_reg |-> RDATA_O[31:2] == 30'h0;
	endproperty
	a_hi_zero: assert property (p_hi_zero)
		else $error("counter high byte upper bits set");
	property p_rst;
		$rose(NRST_I) |-> !BVALID_O && !RVALID_O && !TIMER_OUTPUT_PIN_O && !IRQ_O;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not idle after reset");

	// Main scenarios reached
	c_rd: cover property (RVALID_O && RREADY_I);
	c_irq: cover property ($rose(IRQ_O));
	c_pin: cover property ($fell(TIMER_OUTPUT_PIN_O));
endmodule // tmr_regs_props

bind tmr_regs_top tmr_regs_props u_tmr_regs_props (.SYS_CLK_I, .NRST_I,
	.AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O,
	.BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
	.RVALID_O, .RREADY_I, .TIMER_OUTPUT_PIN_O, .IRQ_O);

`default_nettype wire

// ==== dv/tb_tmr_regs_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module tb_tmr_regs_top
	import tmr_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n, tick, awv, wv, bready, arv, rready;
	logic        awr, wr, bv, arr, rv, pin, irq;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, seed;
	logic [1:0]  bresp, rresp, rr;
	int          error_cnt, checked, m_cnt, m_lim, i;

	tmr_regs_top u_tmr_regs_top (
		.SYS_CLK_I(clk), .NRST_I(rst_n), .TICK_I(tick),
		.AWADDR_I(awaddr), .AWVALID_I(awv), .AWREADY_O(awr),
		.WDATA_I(wdata), .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wr),
		.BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arr),
		.RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rready),
		.TIMER_OUTPUT_PIN_O(pin), .IRQ_O(irq));

	// Free running 200 MHz clock
	always #2.5 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	// Address and data offered together, each released once taken
	task wr_reg(input logic [4:0] a, input logic [31:0] d);
		int t;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		for (t = 0; t < 200 && !(bv && bready); t++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end
		bready <= 1'b0;
		if (t == 200) chk("bvalid", 32'h1, 32'(bv));
	endtask

	task rd_reg(input logic [4:0] a);
		int t;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		for (t = 0; t < 200 && !(rv && rready); t++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end
		rd = rdata;
		rr = rresp;
		rready <= 1'b0;
		if (t == 200) chk("rvalid", 32'h1, 32'(rv));
	endtask

	task rd_chk(input logic [4:0] a, input logic [31:0] e);
		rd_reg(a);
		chk($sformatf("reg %h", a), e, rd);
		chk("resp", 32'(RESP_OKAY), 32'(rr));
	endtask

	// Model steps with every tick; a match clears instead of counting
	task ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			m_cnt = (m_cnt == m_lim) ? 0 : m_cnt + 1;
		end
		@(posedge clk);
		tick <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// Disable first so that enabling is a real rising edge
	task start(input logic [7:0] c1, input logic [2:0] p, input int lim);
		wr_reg(CTRL0_OFFSET, 32'h0);
		wr_reg(CTRL1_OFFSET, {24'h0, c1});
		wr_reg(CTRL0_OFFSET, {24'h0, 5'h01, p});
		m_cnt = 0;
		m_lim = lim;
		repeat (3) @(posedge clk);
	endtask

	task cnt_chk;
		rd_chk(CNT_LOW_OFFSET, 32'(m_cnt & 255));
		rd_chk(CNT_HIGH_OFFSET, 32'(m_cnt >> 8));
	endtask

	task pin_chk(input logic e);
		chk("pin", 32'(e), 32'(pin));
	endtask

	task wrap_up;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		chk("watchdog", 32'h0, 32'h1);
		wrap_up;
	end

	// Main sequence
	initial begin
		{rst_n, tick, awv, wv, bready, arv, rready} = 7'h00;
		{awaddr, araddr, wdata} = 42'h0;
		seed = 32'h43;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) rd_chk(5'(i * 4), 32'h0);
		rd_reg(5'h02);
		chk("resp", 32'(RESP_SLVERR), 32'(rr));
		seed = xs(seed);
		wr_reg(CMPA_LOW_OFFSET, seed & 32'hff);
		rd_chk(CMPA_LOW_OFFSET, seed & 32'hff);
		wr_reg(CMPA_HIGH_OFFSET, 32'hff);
		rd_chk(CMPA_HIGH_OFFSET, 32'h3);
		wr_reg(CNT_LOW_OFFSET, 32'hff);
		rd_chk(CNT_LOW_OFFSET, 32'h0);
		$display("test registers done");
		start(8'h00, 3'h0, 1023);
		ticks(770);
		cnt_chk;
		ticks(260);
		cnt_chk;
		start(8'h00, 3'h1, 128);
		ticks(300);
		cnt_chk;
		$display("test counting done");
		wr_reg(CMPA_LOW_OFFSET, 32'd100);
		wr_reg(CMPA_HIGH_OFFSET, 32'h0);
		wr_reg(IRQ_MASK_OFFSET, 32'h1);
		wr_reg(IRQ_STAT_OFFSET, 32'h3);
		start(8'h39, 3'h1, 100);
		pin_chk(1'b1);
		chk("irq", 32'h0, 32'(irq));
		ticks(101);
		cnt_chk;
		pin_chk(1'b0);
		chk("irq", 32'h1, 32'(irq));
		wr_reg(IRQ_STAT_OFFSET, 32'h1);
		wr_reg(IRQ_MASK_OFFSET, 32'h0);
		ticks(101);
		chk("irq", 32'h0, 32'(irq));
		$display("test compare done");
		start(8'h0c, 3'h0, 1023);
		pin_chk(1'b0);
		start(8'hc8, 3'h0, 1023);
		pin_chk(1'b0);
		wr_reg(CMPA_LOW_OFFSET, 32'd32);
		// Toggle on A at 32, P clears at 128 and must leave the pin
		start(8'h30, 3'h1, 128);
		ticks(140);
		pin_chk(1'b1);
		cnt_chk;
		start(8'ha9, 3'h1, 128);
		ticks(10);
		pin_chk(1'b1);
		ticks(30);
		pin_chk(1'b0);
		ticks(60);
		cnt_chk;
		start(8'ha1, 3'h1, 128);
		ticks(10);
		pin_chk(1'b0);
		start(8'hab, 3'h1, 32);
		ticks(40);
		pin_chk(1'b1);
		cnt_chk;
		// Forced active and inactive levels, then capture ignores clear
		start(8'h98, 3'h1, 128);
		pin_chk(1'b1);
		start(8'h88, 3'h1, 128);
		pin_chk(1'b0);
		start(8'h41, 3'h1, 1023);
		ticks(200);
		cnt_chk;
		$display("test pwm done");
		wrap_up;
	end
endmodule // tb_tmr_regs_top

`default_nettype wire
